// ---- hdl/ssc_pkg.sv ----
// switch statistics counters: shared sizes, ids, event and read carriers
// assumes every event input is synchronous to the core clock, except tx toggles
package ssc_pkg;

  localparam int unsigned NUM_PORTS     = 24;
  localparam int unsigned PORT_W        = 5;
  localparam int unsigned NUM_IDROP     = 40;
  localparam int unsigned IDROP_W       = 6;
  localparam int unsigned NUM_EDROP     = 8;
  localparam int unsigned EDROP_W       = 3;
  localparam int unsigned NUM_ACL       = 32;
  localparam int unsigned ACL_W         = 5;
  localparam int unsigned NUM_PCP       = 8;
  localparam int unsigned PCP_W         = 3;
  localparam int unsigned NUM_SMON_SETS = 2;
  localparam int unsigned NUM_SEARCH    = 8;
  localparam int unsigned NUM_STAGES    = 4;
  localparam int unsigned CNT_W         = 32;
  localparam int unsigned LEN_W         = 16;
  localparam int unsigned VID_W         = 12;
  localparam int unsigned IDX_W         = 8;

  // datapath checkpoint order
  localparam int unsigned STG_INGRESS   = 0;
  localparam int unsigned STG_PBUF      = 1;
  localparam int unsigned STG_EGRESS    = 2;
  localparam int unsigned STG_TXSCHED   = 3;

  localparam logic [IDROP_W-1:0] UNKNOWN_DROP_REASON_INDEX = 6'h00;
  localparam logic [IDROP_W-1:0] EMPTY_MASK_ID   = 6'h01;
  localparam logic [CNT_W-1:0]   CNT_RST         = 32'h0000_0000;

  typedef logic [CNT_W-1:0] ssc_cnt_t;

  typedef enum logic [3:0] {
    GRP_IDROP, GRP_IEDROP, GRP_EDROP, GRP_ACL, GRP_SMON_PKT, GRP_SMON_BYTE,
    GRP_RX_DROPPED, GRP_RX_SA_CHG, GRP_DP_HEAD, GRP_DP_TAIL, GRP_TX_PKT, GRP_TX_ERR
  } ssc_grp_e;

  typedef struct packed {
    logic               valid;
    logic [IDROP_W-1:0] reason;
  } ssc_ing_drop_s;

  typedef struct packed {
    logic                 valid;
    logic [IDROP_W-1:0]   reason;
    logic [NUM_PORTS-1:0] removed;
    logic                 empty;
  } ssc_filt_drop_s;

  typedef struct packed {
    logic               valid;
    logic [EDROP_W-1:0] reason;
    logic [PORT_W-1:0]  port;
  } ssc_epp_drop_s;

  typedef struct packed {
    logic             valid;
    logic             count_en;
    logic [ACL_W-1:0] idx;
  } ssc_acl_s;

  typedef struct packed {
    logic              valid;
    logic [PORT_W-1:0] port;
    logic [VID_W-1:0]  vid;
    logic [PCP_W-1:0]  pcp;
    logic [LEN_W-1:0]  len;
  } ssc_smon_ev_s;

  typedef struct packed {
    logic              valid;
    logic [PORT_W-1:0] port;
    logic [VID_W-1:0]  vid;
    logic              set;
  } ssc_search_s;

  typedef struct packed {
    logic              good_dropped;
    logic              sa_change;
    logic [PORT_W-1:0] port;
  } ssc_rx_ev_s;

  typedef struct packed {
    logic [NUM_STAGES-1:0] head;
    logic [NUM_STAGES-1:0] tail;
  } ssc_dp_ev_s;

  typedef struct packed {
    logic             valid;
    ssc_grp_e         grp;
    logic [IDX_W-1:0] idx_a;
    logic [IDX_W-1:0] idx_b;
  } ssc_rd_req_s;

  typedef struct packed {
    logic     valid;
    logic     err;
    ssc_cnt_t data;
  } ssc_rd_rsp_s;

endpackage : ssc_pkg

// ---- hdl/ssc_tgl_sync.sv ----
// ssc_tgl_sync: toggle event from the tx mac clock into a one-cycle core pulse
// assumes the far side flips tgl_in once per event, slower than two core cycles
module ssc_tgl_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tgl_in,
  output logic      pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } ssc_tgl_st_s;

  ssc_tgl_st_s st_q;
  ssc_tgl_st_s st_d;

  always_comb begin
    st_d       = st_q;
    st_d.meta  = tgl_in;
    st_d.sync  = st_q.meta;
    st_d.last  = st_q.sync;
    st_d.pulse = st_q.sync ^ st_q.last;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

endmodule // ssc_tgl_sync

// ---- hdl/ssc_stats.sv ----
// ssc_stats: statistics counters of the switch core, fed by pipeline events
// assumes event inputs are core-clock synchronous; tx toggles come from the tx mac clock
// How it works
// - every counter is 32 bits and wraps around on overflow, dropping the carry out of bit 31.
// - each egress drop reason and each ingress drop reason below 40 has its own index and its own counter.
// - ingress drop array counts drops before any destination port is assigned.
// - filtering away every destination bumps the empty-destination-mask counter.
// - ingress keeps per reason and egress port counters for removed destinations.
// - a filter drop that empties the mask also bumps the empty-mask counter.
// - egress pipeline keeps per reason and egress port drop counters.
// - a counting classification match bumps the counter its result selects.
// - two traffic-monitoring sets, a packet and a byte counter per priority code point each.
// - set chosen by ingress port and VLAN id through a search table.
// - each monitoring set counts packets and bytes per priority.
// - per ingress port count good-then-dropped and broadcast source-address-change packets.
// - head and tail counters for ingress, buffer, egress, scheduler stages.
// - no counters live in the receive mac clock.
// - tx packet and tx error events cross into core clock for counting.
// - drop paths land in dedicated counters; ingress and filter reasons 40 to 63 get no per-reason count, but an emptied mask bumps the empty-mask counter.
// - counted value stays exact; only crossing of events is synchronized.
module ssc_stats
  import ssc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  ssc_pkg::ssc_ing_drop_s      ing_drop,
  input  ssc_pkg::ssc_filt_drop_s     filt_drop,
  input  ssc_pkg::ssc_epp_drop_s      epp_drop,
  input  ssc_pkg::ssc_acl_s           acl_hit,
  input  ssc_pkg::ssc_smon_ev_s       smon_ev,
  input  ssc_pkg::ssc_search_s        smon_search [ssc_pkg::NUM_SEARCH],
  input  ssc_pkg::ssc_rx_ev_s         rx_ev,
  input  ssc_pkg::ssc_dp_ev_s         dp_ev,
  input  wire logic [ssc_pkg::NUM_PORTS-1:0] tx_pkt_tgl,
  input  wire logic [ssc_pkg::NUM_PORTS-1:0] tx_err_tgl,
  input  ssc_pkg::ssc_rd_req_s        rd_req,
  output ssc_pkg::ssc_rd_rsp_s        rd_rsp
);

  import ssc_pkg::*;

  typedef struct packed {
    ssc_cnt_t [NUM_IDROP-1:0]                     idrop;
    ssc_cnt_t [NUM_IDROP-1:0][NUM_PORTS-1:0]      iedrop;
    ssc_cnt_t [NUM_EDROP-1:0][NUM_PORTS-1:0]      edrop;
    ssc_cnt_t [NUM_ACL-1:0]                       acl;
    ssc_cnt_t [NUM_SMON_SETS-1:0][NUM_PCP-1:0]    smon_pkt;
    ssc_cnt_t [NUM_SMON_SETS-1:0][NUM_PCP-1:0]    smon_byte;
    ssc_cnt_t [NUM_PORTS-1:0]                     rx_dropped;
    ssc_cnt_t [NUM_PORTS-1:0]                     rx_sa_chg;
    ssc_cnt_t [NUM_STAGES-1:0]                    dp_head;
    ssc_cnt_t [NUM_STAGES-1:0]                    dp_tail;
    ssc_cnt_t [NUM_PORTS-1:0]                     tx_pkt;
    ssc_cnt_t [NUM_PORTS-1:0]                     tx_err;
    ssc_rd_rsp_s                                  rsp;
  } ssc_st_s;

  ssc_st_s               st_q;
  ssc_st_s               st_d;
  logic [NUM_PORTS-1:0]  tx_pkt_pls;
  logic [NUM_PORTS-1:0]  tx_err_pls;

  // tx mac events: only the event crosses, the count itself lives here
  for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_tx_sync
    ssc_tgl_sync u_pkt_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .tgl_in (tx_pkt_tgl[gp]),
      .pulse  (tx_pkt_pls[gp])
    );
    ssc_tgl_sync u_err_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .tgl_in (tx_err_tgl[gp]),
      .pulse  (tx_err_pls[gp])
    );
  end

  always_comb begin
    logic              smon_hit;
    logic              smon_set;
    logic              empty_inc;
    logic              ing_inc;
    logic [IDX_W-1:0]  ia;
    logic [IDX_W-1:0]  ib;
    smon_hit  = 1'b0;
    smon_set  = 1'b0;
    empty_inc = 1'b0;
    ing_inc   = 1'b0;
    ia        = rd_req.idx_a;
    ib        = rd_req.idx_b;
    st_d      = st_q;

    // ingress drops by reason; empty-mask entry takes both paths in one cycle
    empty_inc = filt_drop.valid && filt_drop.empty;
    for (int i = 0; i < NUM_IDROP; i++) begin
      ing_inc = ing_drop.valid && (ing_drop.reason == IDROP_W'(i));
      st_d.idrop[i] = st_q.idrop[i] + {31'h0000_0000, ing_inc}
                      + {31'h0000_0000, empty_inc && (IDROP_W'(i) == EMPTY_MASK_ID)};
    end

    // destinations removed after assignment, one count per removed port
    for (int i = 0; i < NUM_IDROP; i++) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (filt_drop.valid && filt_drop.reason == IDROP_W'(i) && filt_drop.removed[p]) begin
          st_d.iedrop[i][p] = st_q.iedrop[i][p] + 32'h0000_0001;
        end
      end
    end

    // egress pipeline drops; the packet leaves a gap, nothing replaces it
    for (int i = 0; i < NUM_EDROP; i++) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (epp_drop.valid && epp_drop.reason == EDROP_W'(i) && epp_drop.port == PORT_W'(p)) begin
          st_d.edrop[i][p] = st_q.edrop[i][p] + 32'h0000_0001;
        end
      end
    end

    // classification result counters
    for (int i = 0; i < NUM_ACL; i++) begin
      if (acl_hit.valid && acl_hit.count_en && acl_hit.idx == ACL_W'(i)) begin
        st_d.acl[i] = st_q.acl[i] + 32'h0000_0001;
      end
    end

    // monitoring set search: lowest matching entry wins, no match counts nothing
    for (int e = NUM_SEARCH - 1; e >= 0; e--) begin
      if (smon_search[e].valid && smon_search[e].port == smon_ev.port
          && smon_search[e].vid == smon_ev.vid) begin
        smon_hit = 1'b1;
        smon_set = smon_search[e].set;
      end
    end
    for (int s = 0; s < NUM_SMON_SETS; s++) begin
      for (int c = 0; c < NUM_PCP; c++) begin
        if (smon_ev.valid && smon_hit && smon_set == 1'(s) && smon_ev.pcp == PCP_W'(c)) begin
          st_d.smon_pkt[s][c]  = st_q.smon_pkt[s][c] + 32'h0000_0001;
          st_d.smon_byte[s][c] = st_q.smon_byte[s][c] + {16'h0000, smon_ev.len};
        end
      end
    end

    // per ingress port receive counters and per port tx packet and tx error counters
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (rx_ev.good_dropped && rx_ev.port == PORT_W'(p)) begin
        st_d.rx_dropped[p] = st_q.rx_dropped[p] + 32'h0000_0001;
      end
      if (rx_ev.sa_change && rx_ev.port == PORT_W'(p)) begin
        st_d.rx_sa_chg[p] = st_q.rx_sa_chg[p] + 32'h0000_0001;
      end
      st_d.tx_pkt[p] = st_q.tx_pkt[p] + {31'h0000_0000, tx_pkt_pls[p]};
      st_d.tx_err[p] = st_q.tx_err[p] + {31'h0000_0000, tx_err_pls[p]};
    end

    // datapath checkpoints; no rx mac clock counters exist at all
    for (int g = 0; g < NUM_STAGES; g++) begin
      st_d.dp_head[g] = st_q.dp_head[g] + {31'h0000_0000, dp_ev.head[g]};
      st_d.dp_tail[g] = st_q.dp_tail[g] + {31'h0000_0000, dp_ev.tail[g]};
    end

    // readout: plain look at the stored value, counting carries on
    st_d.rsp.valid = rd_req.valid;
    st_d.rsp.err   = 1'b0;
    st_d.rsp.data  = CNT_RST;
    if (rd_req.valid) begin
      case (rd_req.grp)
        GRP_IDROP: begin
          if (ia < IDX_W'(NUM_IDROP)) st_d.rsp.data = st_q.idrop[ia];
          else st_d.rsp.err = 1'b1;
        end
        GRP_IEDROP: begin
          if (ia < IDX_W'(NUM_IDROP) && ib < IDX_W'(NUM_PORTS)) st_d.rsp.data = st_q.iedrop[ia][ib];
          else st_d.rsp.err = 1'b1;
        end
        GRP_EDROP: begin
          if (ia < IDX_W'(NUM_EDROP) && ib < IDX_W'(NUM_PORTS)) st_d.rsp.data = st_q.edrop[ia][ib];
          else st_d.rsp.err = 1'b1;
        end
        GRP_ACL: begin
          if (ia < IDX_W'(NUM_ACL)) st_d.rsp.data = st_q.acl[ia];
          else st_d.rsp.err = 1'b1;
        end
        GRP_SMON_PKT: begin
          if (ia < IDX_W'(NUM_SMON_SETS) && ib < IDX_W'(NUM_PCP)) st_d.rsp.data = st_q.smon_pkt[ia][ib];
          else st_d.rsp.err = 1'b1;
        end
        GRP_SMON_BYTE: begin
          if (ia < IDX_W'(NUM_SMON_SETS) && ib < IDX_W'(NUM_PCP)) st_d.rsp.data = st_q.smon_byte[ia][ib];
          else st_d.rsp.err = 1'b1;
        end
        GRP_RX_DROPPED: begin
          if (ia < IDX_W'(NUM_PORTS)) st_d.rsp.data = st_q.rx_dropped[ia];
          else st_d.rsp.err = 1'b1;
        end
        GRP_RX_SA_CHG: begin
          if (ia < IDX_W'(NUM_PORTS)) st_d.rsp.data = st_q.rx_sa_chg[ia];
          else st_d.rsp.err = 1'b1;
        end
        GRP_DP_HEAD: begin
          if (ia < IDX_W'(NUM_STAGES)) st_d.rsp.data = st_q.dp_head[ia];
          else st_d.rsp.err = 1'b1;
        end
        GRP_DP_TAIL: begin
          if (ia < IDX_W'(NUM_STAGES)) st_d.rsp.data = st_q.dp_tail[ia];
          else st_d.rsp.err = 1'b1;
        end
        GRP_TX_PKT: begin
          if (ia < IDX_W'(NUM_PORTS)) st_d.rsp.data = st_q.tx_pkt[ia];
          else st_d.rsp.err = 1'b1;
        end
        GRP_TX_ERR: begin
          if (ia < IDX_W'(NUM_PORTS)) st_d.rsp.data = st_q.tx_err[ia];
          else st_d.rsp.err = 1'b1;
        end
        default: begin
          st_d.rsp.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_rsp = st_q.rsp;

endmodule // ssc_stats

// ---- verification/ssc_stats_chk.sv ----
// ssc_stats_chk: read-port timing and refusal checks on ssc_stats
// assumes it is bound to ssc_stats and sees only its ports
module ssc_stats_chk
  import ssc_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_n,
  input ssc_pkg::ssc_rd_req_s rd_req,
  input ssc_pkg::ssc_rd_rsp_s rd_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rsp_next; rd_req.valid |=> rd_rsp.valid; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("read not answered");
  property p_rsp_only; !rd_req.valid |=> !rd_rsp.valid; endproperty
  a_rsp_only: assert property (p_rsp_only) else $error("unrequested answer");
  property p_err_zero; rd_rsp.err |-> rd_rsp.data == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read with data");
  property p_err_valid; rd_rsp.err |-> rd_rsp.valid; endproperty
  a_err_valid: assert property (p_err_valid) else $error("error without answer");
  property p_bad_grp; rd_req.valid && rd_req.grp > GRP_TX_ERR |=> rd_rsp.err; endproperty
  a_bad_grp: assert property (p_bad_grp) else $error("bad group accepted");
  property p_acl_range;
    rd_req.valid && rd_req.grp == GRP_ACL |=> rd_rsp.err == ($past(rd_req.idx_a) >= 8'h20);
  endproperty
  a_acl_range: assert property (p_acl_range) else $error("acl index range wrong");
  property p_smon_range;
    rd_req.valid && rd_req.grp == GRP_SMON_PKT && rd_req.idx_a > 8'h01 && rd_req.idx_b < 8'h08 |=> rd_rsp.err;
  endproperty
  a_smon_range: assert property (p_smon_range) else $error("third monitor set");
  property p_stage_range;
    rd_req.valid && rd_req.grp == GRP_DP_HEAD |=> rd_rsp.err == ($past(rd_req.idx_a) > 8'h03);
  endproperty
  a_stage_range: assert property (p_stage_range) else $error("stage range wrong");
  c_tx: cover property (rd_req.valid && rd_req.grp == GRP_TX_PKT);
  c_smon: cover property (rd_req.valid && rd_req.grp == GRP_SMON_BYTE);
  c_err: cover property (rd_rsp.err);
endmodule // ssc_stats_chk

bind ssc_stats ssc_stats_chk ssc_stats_chk_inst (.clk(clk), .rst_n(rst_n), .rd_req(rd_req), .rd_rsp(rd_rsp));

// ---- verification/ssc_tx_mac_model.sv ----
// ssc_tx_mac_model: tx mac side, flips a toggle per sent packet or protocol error
// assumes the bench spaces events on one port at least three core cycles apart
module ssc_tx_mac_model
  import ssc_pkg::*;
(
  input  wire logic [ssc_pkg::NUM_PORTS-1:0] pkt_ev,
  input  wire logic [ssc_pkg::NUM_PORTS-1:0] err_ev,
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  output logic      [ssc_pkg::NUM_PORTS-1:0] tx_pkt_tgl,
  output logic      [ssc_pkg::NUM_PORTS-1:0] tx_err_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pkt_tgl <= '0;
      tx_err_tgl <= '0;
    end else begin
      tx_pkt_tgl <= tx_pkt_tgl ^ pkt_ev;
      tx_err_tgl <= tx_err_tgl ^ err_ev;
    end
  end
endmodule // ssc_tx_mac_model

// ---- verification/switch_statistics_counters_bench.sv ----
// switch_statistics_counters_bench: directed scenarios on ssc_stats
// assumes ssc_stats_chk is bound by its own file
module switch_statistics_counters_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  `define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin \
    errors++; $display("MISMATCH t=%0t %s", $time, msg); end end

  logic                 clk;
  logic                 rst_n;
  ssc_ing_drop_s        ing_drop;
  ssc_filt_drop_s       filt_drop;
  ssc_epp_drop_s        epp_drop;
  ssc_acl_s             acl_hit;
  ssc_smon_ev_s         smon_ev;
  ssc_search_s          smon_search [NUM_SEARCH];
  ssc_rx_ev_s           rx_ev;
  ssc_dp_ev_s           dp_ev;
  logic [NUM_PORTS-1:0] tx_pkt_tgl, tx_err_tgl, pkt_ev, err_ev;
  ssc_rd_req_s          rd_req;
  ssc_rd_rsp_s          rd_rsp;
  int                   errors;
  int                   n_checks;

  ssc_stats ssc_stats_inst (.clk(clk), .rst_n(rst_n), .ing_drop(ing_drop), .filt_drop(filt_drop),
    .epp_drop(epp_drop), .acl_hit(acl_hit), .smon_ev(smon_ev), .smon_search(smon_search), .rx_ev(rx_ev),
    .dp_ev(dp_ev), .tx_pkt_tgl(tx_pkt_tgl), .tx_err_tgl(tx_err_tgl), .rd_req(rd_req), .rd_rsp(rd_rsp));
  ssc_tx_mac_model ssc_tx_mac_model_inst (.pkt_ev(pkt_ev), .err_ev(err_ev), .clk(clk), .rst_n(rst_n),
    .tx_pkt_tgl(tx_pkt_tgl), .tx_err_tgl(tx_err_tgl));

  task automatic clear_ev;
    ing_drop <= '0;
    filt_drop <= '0;
    epp_drop <= '0;
    acl_hit <= '0;
    smon_ev <= '0;
    rx_ev <= '0;
    dp_ev <= '0;
    pkt_ev <= '0;
    err_ev <= '0;
  endtask

  task automatic rd(input ssc_grp_e g, input logic [7:0] a, input logic [7:0] b, input ssc_cnt_t exp,
                    input logic e = 1'b0);
    @(posedge clk);
    rd_req <= '{1'b1, g, a, b};
    @(posedge clk);
    rd_req.valid <= 1'b0;
    #1;
    `CHK(rd_rsp.valid, 1'b1, "no answer")
    `CHK(rd_rsp.err, e, "error flag")
    `CHK(rd_rsp.data, exp, "count value")
  endtask

  task automatic s_drops;
    rd(GRP_IDROP, 8'h05, 8'h00, 32'h0000_0000);
    repeat (3) begin
      @(posedge clk);
      ing_drop <= '{1'b1, 6'h05};
    end
    @(posedge clk);
    ing_drop <= '{1'b1, EMPTY_MASK_ID};
    filt_drop <= '{1'b1, 6'h07, 24'h00_0204, 1'b1};
    @(posedge clk);
    clear_ev();
    rd(GRP_IDROP, 8'h05, 8'h00, 32'h0000_0003);
    rd(GRP_IDROP, 8'h01, 8'h00, 32'h0000_0002);
    rd(GRP_IEDROP, 8'h07, 8'h09, 32'h0000_0001);
    rd(GRP_IEDROP, 8'h07, 8'h03, 32'h0000_0000);
  endtask

  task automatic s_paths;
    @(posedge clk);
    epp_drop <= '{1'b1, 3'h3, 5'h04};
    acl_hit <= '{1'b1, 1'b0, 5'h02};
    rx_ev <= '{1'b1, 1'b1, 5'h04};
    dp_ev <= '{4'hF, 4'h4};
    @(posedge clk);
    clear_ev();
    @(posedge clk);
    acl_hit <= '{1'b1, 1'b1, 5'h1F};
    @(posedge clk);
    acl_hit <= '0;
    rd(GRP_EDROP, 8'h03, 8'h04, 32'h0000_0001);
    rd(GRP_ACL, 8'h02, 8'h00, 32'h0000_0000);
    rd(GRP_ACL, 8'h1F, 8'h00, 32'h0000_0001);
    rd(GRP_ACL, 8'h20, 8'h00, 32'h0000_0000, 1'b1);
    // read and event on one counter in the same cycle
    @(posedge clk);
    rd_req <= '{1'b1, GRP_ACL, 8'h1F, 8'h00};
    acl_hit <= '{1'b1, 1'b1, 5'h1F};
    @(posedge clk);
    rd_req.valid <= 1'b0;
    acl_hit <= '0;
    #1;
    `CHK(rd_rsp.data, 32'h0000_0001, "value before event")
    rd(GRP_ACL, 8'h1F, 8'h00, 32'h0000_0002);
    rd(GRP_RX_DROPPED, 8'h04, 8'h00, 32'h0000_0001);
    rd(GRP_RX_SA_CHG, 8'h04, 8'h00, 32'h0000_0001);
    for (int g = 0; g < 4; g++) begin
      rd(GRP_DP_HEAD, 8'(g), 8'h00, 32'h0000_0001);
      rd(GRP_DP_TAIL, 8'(g), 8'h00, (g == 2) ? 32'h0000_0001 : 32'h0000_0000);
    end
    rd(GRP_DP_HEAD, 8'h04, 8'h00, 32'h0000_0000, 1'b1);
    rd(ssc_grp_e'(4'hC), 8'h00, 8'h00, 32'h0000_0000, 1'b1);
  endtask

  task automatic s_smon;
    @(posedge clk);
    smon_ev <= '{1'b1, 5'h02, 12'h064, 3'h5, 16'h0040};
    @(posedge clk);
    smon_ev <= '{1'b1, 5'h02, 12'h065, 3'h5, 16'h0040};
    @(posedge clk);
    smon_ev <= '{1'b1, 5'h02, 12'h064, 3'h5, 16'h0040};
    @(posedge clk);
    smon_ev <= '0;
    rd(GRP_SMON_PKT, 8'h01, 8'h05, 32'h0000_0002);
    rd(GRP_SMON_BYTE, 8'h01, 8'h05, 32'h0000_0080);
    rd(GRP_SMON_PKT, 8'h00, 8'h05, 32'h0000_0000);
    rd(GRP_SMON_PKT, 8'h02, 8'h05, 32'h0000_0000, 1'b1);
    rd(GRP_SMON_PKT, 8'h01, 8'h05, 32'h0000_0002);
  endtask

  task automatic s_tx;
    @(posedge clk);
    pkt_ev <= 24'h00_0040;
    err_ev <= 24'h00_0040;
    @(posedge clk);
    pkt_ev <= '0;
    err_ev <= '0;
    repeat (3) @(posedge clk);
    pkt_ev <= 24'h00_0040;
    @(posedge clk);
    pkt_ev <= '0;
    repeat (6) @(posedge clk);
    rd(GRP_TX_PKT, 8'h06, 8'h00, 32'h0000_0002);
    rd(GRP_TX_ERR, 8'h06, 8'h00, 32'h0000_0001);
    rd(GRP_TX_PKT, 8'h05, 8'h00, 32'h0000_0000);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    rst_n <= 1'b0;
    rd_req <= '0;
    clear_ev();
    // entries 0 and 1 both match port 2 vid 100; entry 0 must win with set 1
    foreach (smon_search[i]) smon_search[i] <= (i > 1) ? ssc_search_s'('0)
                                                       : ssc_search_s'{1'b1, 5'h02, 12'h064, i == 0};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_drops();
    s_paths();
    s_smon();
    s_tx();
    tally_and_finish();
  end
endmodule // switch_statistics_counters_bench
